// file: ufc_ctrl.v
// Summary of operation
// - Deallocate on complete; disable on overrun
// - Program config, unmask interrupts, clear disconnect
// - On reset: NAK outs, unmask ep0 interrupts
// - Size receive and ep0 transmit FIFOs
// - Clear address, load setup count three
// - After enumeration set ep0 size, unmask SOF
// - SetAddress: write address, send status IN
// - Reconfigure endpoint, then endpoint interrupt mask
// - Stop pending transfer before clearing valid
// - SETUP flag set; reload setup count three
// - Ep0 OUT chunk at most sixty-four bytes
// - Re-enable control OUT on SETUP or complete
`include "ufc_defs.vh"

module ufc_ctrl #(
  parameter NUM_OUT_EP = 4,
  parameter NUM_EP = 4
) (
  input wire clk,
  input wire rst_n,
  input wire s_psel,
  input wire s_penable,
  input wire [7:0] s_paddr,
  input wire s_pwrite,
  input wire [31:0] s_pwdata,
  output reg [31:0] s_prdata,
  output wire s_pready,
  output wire s_pslverr,
  input wire dev_irq,
  output wire m_psel,
  output wire m_penable,
  output wire [31:0] m_paddr,
  output wire m_pwrite,
  output wire [31:0] m_pwdata,
  input wire [31:0] m_prdata,
  input wire m_pready
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ISSUE = 3'b010;
  localparam ST_WAIT = 3'b100;
  localparam [31:0] LAST_EP_W = NUM_OUT_EP - 1;
  localparam [3:0] LAST_EP = LAST_EP_W[3:0];

  reg rst_q1;
  reg rst_q2;
  wire rst_sync_n;
  wire irq_s;
  reg [2:0] state;
  reg [3:0] script;
  reg [3:0] step;
  reg [3:0] ep_cnt;
  reg [31:0] rd_val;
  reg [31:0] gsts;
  reg [1:0] enum_speed;
  reg connected;
  reg [NUM_EP-1:0] ep_act;
  reg [5:0] pend;
  reg [5:0] events;
  reg [31:0] cfg;
  reg [31:0] epcfg;
  reg [31:0] txdata;
  wire mdone;
  wire [31:0] mrdata;
  wire mreq;
  reg [31:0] op_addr;
  reg [31:0] op_data;
  reg op_wr;
  reg op_last;
  reg op_skip;
  wire op_finish;
  reg [3:0] poll_next;
  reg [3:0] cmd_script;
  reg [5:0] pend_clr;
  reg [5:0] ev_set;
  wire [3:0] ep_num;
  wire [31:0] ep_off;
  wire [NUM_EP-1:0] ep_bit;
  wire [NUM_EP-1:0] act_mask;
  wire [31:0] daint_val;
  wire [10:0] mps0;
  wire [31:0] dcfg_base;
  wire [31:0] gmask;
  wire [31:0] ep_ctl;
  wire wr_en;
  wire mapped;

  // --------------------------------------------------------------------
  // Reset release and interrupt pin
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  assign rst_sync_n = rst_q2;

  ufc_sync u_irq (
    .clk(clk),
    .rst_n(rst_sync_n),
    .din(dev_irq),
    .dout(irq_s)
  );

  // --------------------------------------------------------------------
  // Device bus master
  // --------------------------------------------------------------------
  assign mreq = (state == ST_ISSUE) && !op_skip;

  ufc_apb_master u_mst (
    .clk(clk),
    .rst_n(rst_sync_n),
    .req(mreq),
    .req_write(op_wr),
    .req_addr(op_addr),
    .req_wdata(op_data),
    .done(mdone),
    .rdata(mrdata),
    .psel(m_psel),
    .penable(m_penable),
    .paddr(m_paddr),
    .pwrite(m_pwrite),
    .pwdata(m_pwdata),
    .prdata(m_prdata),
    .pready(m_pready)
  );

  // --------------------------------------------------------------------
  // Operation table
  // --------------------------------------------------------------------
  assign ep_num = epcfg[3:0];
  assign ep_off = {28'h0000000, ep_num} << `UFC_EP_SHIFT;
  assign ep_bit = {{(NUM_EP-1){1'b0}}, 1'b1} << ep_num;
  assign act_mask = ep_act | {{(NUM_EP-1){1'b0}}, 1'b1};
  assign daint_val = {{(16-NUM_EP){1'b0}}, act_mask,
                      {(16-NUM_EP){1'b0}}, act_mask};
  assign mps0 = (enum_speed == `UFC_SPD_FULL) ? `UFC_EP0_MPS :
                `UFC_EP0_MPS_LOW;
  assign dcfg_base = {27'h0000000, cfg[4:0]};
  assign gmask = `UFC_GI_RST | `UFC_GI_ENUM | `UFC_GI_ESUSP |
                 `UFC_GI_SUSP | `UFC_GI_SOF | `UFC_GI_OEP |
                 `UFC_GI_IEP | `UFC_GI_HCH;
  assign ep_ctl = {21'h000000, epcfg[14:4]} | `UFC_EC_VALID |
                  ({30'h00000000, epcfg[16:15]} << `UFC_EC_TYPE_LSB) |
                  ({28'h0000000, epcfg[20:17]} << `UFC_EC_TXF_LSB) |
                  (epcfg[21] ? `UFC_EC_DATA0 : 32'h00000000);

  always @* begin
    op_addr = `UFC_D_GINTSTS;
    op_data = 32'h00000000;
    op_wr = 1'b1;
    op_last = 1'b0;
    op_skip = 1'b0;
    case (script)
      `UFC_SC_POLL: begin
        op_wr = 1'b0;
        op_last = 1'b1;
      end
      `UFC_SC_INIT: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_DCFG;
            op_data = dcfg_base;
          end
          4'h1: begin
            op_addr = `UFC_D_GINTMSK;
            op_data = gmask;
          end
          default: begin
            op_addr = `UFC_D_DCTL;
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_RESET: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_DOEPCTL0 + ({28'h0000000, ep_cnt} <<
                      `UFC_EP_SHIFT);
            op_data = `UFC_EC_SET_NAK;
          end
          4'h1: begin
            op_addr = `UFC_D_ENDPOINT_INTERRUPT_MASK_REG;
            op_data = daint_val;
          end
          4'h2: begin
            op_addr = `UFC_D_DOEPMSK;
            op_data = `UFC_OI_SETUP | `UFC_OI_TRANSFER_COMPLETE_FLAG;
          end
          4'h3: begin
            op_addr = `UFC_D_DIEPMSK;
            op_data = `UFC_OI_TRANSFER_COMPLETE_FLAG | `UFC_IM_TMO;
          end
          4'h4: begin
            op_addr = `UFC_D_GRXFSIZ;
            op_data = {16'h0000, `UFC_RX_WORDS};
          end
          4'h5: begin
            op_addr = `UFC_D_DIEPTXF0;
            op_data = {`UFC_TX0_WORDS, `UFC_RX_WORDS};
          end
          4'h6: begin
            op_addr = `UFC_D_DCFG;
            op_data = dcfg_base;
          end
          4'h7: begin
            op_addr = `UFC_D_DOEPTSIZ0;
            op_data = `UFC_TS_SUP3;
          end
          default: begin
            op_data = `UFC_GI_RST;
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_ENUM: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_DSTS;
            op_wr = 1'b0;
          end
          4'h1: begin
            op_addr = `UFC_D_DIEPCTL0;
            op_data = {21'h000000, mps0};
          end
          4'h2: begin
            op_addr = `UFC_D_GINTMSK;
            op_data = gmask;
          end
          default: begin
            op_data = `UFC_GI_ENUM;
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_OEP: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_DOEPINT0;
            op_wr = 1'b0;
          end
          4'h1: begin
            op_addr = `UFC_D_DOEPTSIZ0;
            op_data = `UFC_TS_SUP3 | `UFC_TS_PKT1 |
                      `UFC_EP0_CHUNK;
          end
          4'h2: begin
            op_addr = `UFC_D_DOEPINT0;
            op_data = rd_val;
          end
          default: begin
            op_addr = `UFC_D_DOEPCTL0;
            op_data = `UFC_EC_ENA | `UFC_EC_CNAK;
            op_skip = !(rd_val[0] || rd_val[3]);
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_HCH: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_HCINT;
            op_wr = 1'b0;
          end
          4'h1: begin
            op_addr = (rd_val & `UFC_HI_TRANSFER_COMPLETE_FLAG) != 32'h0 ?
                      `UFC_D_HCCHAR : `UFC_D_HCINTMSK;
            op_data = (rd_val & `UFC_HI_OVRUN) != 32'h0 ?
                      (`UFC_HI_TRANSFER_COMPLETE_FLAG | `UFC_HI_OVRUN | `UFC_HI_HALT) :
                      (`UFC_HI_TRANSFER_COMPLETE_FLAG | `UFC_HI_OVRUN);
            if ((rd_val & `UFC_HI_TRANSFER_COMPLETE_FLAG) != 32'h0) begin
              op_data = 32'h00000000;
            end
          end
          4'h2: begin
            op_addr = `UFC_D_HCCHAR;
            op_data = (rd_val & `UFC_HI_OVRUN) != 32'h0 ?
                      (`UFC_EC_ENA | `UFC_EC_DIS) : 32'h00000000;
            op_skip = (rd_val & `UFC_HI_TRANSFER_COMPLETE_FLAG) != 32'h0;
          end
          default: begin
            op_addr = `UFC_D_HCINT;
            op_data = rd_val;
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_IEP: begin
        op_addr = `UFC_D_DIEPINT0;
        op_wr = (step != 4'h0);
        op_data = rd_val;
        op_last = (step != 4'h0);
      end
      `UFC_SC_SADDR: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_DCFG;
            op_data = dcfg_base | ({25'h0000000, cfg[11:5]} <<
                      `UFC_DCFG_ADDR_LSB);
          end
          4'h1: begin
            op_addr = `UFC_D_DIEPTSIZ0;
            op_data = `UFC_TS_PKT1;
          end
          default: begin
            op_addr = `UFC_D_DIEPCTL0;
            op_data = `UFC_EC_ENA | `UFC_EC_CNAK |
                      {21'h000000, mps0};
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_ACT: begin
        op_addr = (step == 4'h0) ? (`UFC_D_DIEPCTL0 + ep_off) :
                  `UFC_D_ENDPOINT_INTERRUPT_MASK_REG;
        op_data = (step == 4'h0) ? ep_ctl : daint_val;
        op_last = (step != 4'h0);
      end
      `UFC_SC_DEACT: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_DIEPCTL0 + ep_off;
            op_data = `UFC_EC_DIS | `UFC_EC_SET_NAK;
          end
          4'h1: begin
            op_addr = `UFC_D_DIEPCTL0 + ep_off;
          end
          default: begin
            op_addr = `UFC_D_ENDPOINT_INTERRUPT_MASK_REG;
            op_data = daint_val;
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_CHAN: begin
        case (step)
          4'h0: begin
            op_addr = `UFC_D_HCINTMSK;
            op_data = `UFC_HI_TRANSFER_COMPLETE_FLAG | `UFC_HI_OVRUN;
          end
          4'h1: begin
            op_addr = `UFC_D_HCTSIZ;
            op_data = `UFC_TS_PKT1 | {21'h000000, epcfg[14:4]};
          end
          default: begin
            op_addr = `UFC_D_HCCHAR;
            op_data = `UFC_HC_ODD | `UFC_HC_ISO | `UFC_EC_ENA |
                      {21'h000000, epcfg[14:4]};
            op_last = 1'b1;
          end
        endcase
      end
      `UFC_SC_PUSH: begin
        op_addr = `UFC_D_CHFIFO;
        op_data = txdata;
        op_last = 1'b1;
      end
      default: begin
        op_data = gsts;
        op_last = 1'b1;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Dispatch
  // --------------------------------------------------------------------
  assign op_finish = ((state == ST_ISSUE) && op_skip) ||
                     ((state == ST_WAIT) && mdone);

  always @* begin
    poll_next = `UFC_SC_CLR;
    if ((mrdata & `UFC_GI_RST) != 32'h0) begin
      poll_next = `UFC_SC_RESET;
    end else if ((mrdata & `UFC_GI_ENUM) != 32'h0) begin
      poll_next = `UFC_SC_ENUM;
    end else if ((mrdata & `UFC_GI_OEP) != 32'h0) begin
      poll_next = `UFC_SC_OEP;
    end else if ((mrdata & `UFC_GI_IEP) != 32'h0) begin
      poll_next = `UFC_SC_IEP;
    end else if ((mrdata & `UFC_GI_HCH) != 32'h0) begin
      poll_next = `UFC_SC_HCH;
    end
    pend_clr = pend & (~pend + 6'h01);
    case (pend_clr)
      6'h01: cmd_script = `UFC_SC_INIT;
      6'h02: cmd_script = `UFC_SC_SADDR;
      6'h04: cmd_script = `UFC_SC_ACT;
      6'h08: cmd_script = `UFC_SC_DEACT;
      6'h10: cmd_script = `UFC_SC_CHAN;
      default: cmd_script = `UFC_SC_PUSH;
    endcase
    if ((state != ST_IDLE) || irq_s) begin
      pend_clr = 6'h00;
    end
    ev_set = 6'h00;
    if (op_finish && (step == 4'h0)) begin
      case (script)
        `UFC_SC_ENUM: ev_set[1] = 1'b1;
        `UFC_SC_OEP: ev_set[3:2] = {mrdata[0], mrdata[3]};
        `UFC_SC_HCH: ev_set[5:4] = mrdata[1:0];
        default: ev_set = 6'h00;
      endcase
    end
    if (op_finish && op_last && (script == `UFC_SC_RESET)) begin
      ev_set[0] = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      script <= `UFC_SC_POLL;
      step <= 4'h0;
      ep_cnt <= 4'h0;
      rd_val <= 32'h00000000;
      gsts <= 32'h00000000;
      enum_speed <= 2'h0;
      connected <= 1'b0;
      ep_act <= {NUM_EP{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          step <= 4'h0;
          ep_cnt <= 4'h0;
          if (irq_s) begin
            script <= `UFC_SC_POLL;
            state <= ST_ISSUE;
          end else if (pend != 6'h00) begin
            script <= cmd_script;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (!op_skip) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
        end
        default: state <= ST_IDLE;
      endcase
      if (op_finish) begin
        if (!op_wr && !op_skip) begin
          rd_val <= mrdata;
        end
        if (script == `UFC_SC_POLL) begin
          gsts <= mrdata;
        end
        if ((script == `UFC_SC_ENUM) && (step == 4'h0)) begin
          enum_speed <= mrdata[`UFC_DS_SPD];
        end
        if ((script == `UFC_SC_ACT) && (step == 4'h0)) begin
          ep_act <= ep_act | ep_bit;
        end
        if ((script == `UFC_SC_DEACT) && (step == 4'h1)) begin
          ep_act <= ep_act & ~ep_bit;
        end
        if ((script == `UFC_SC_INIT) && op_last) begin
          connected <= 1'b1;
        end
        if (op_last && (script == `UFC_SC_POLL)) begin
          script <= poll_next;
          step <= 4'h0;
          state <= ST_ISSUE;
        end else if (op_last) begin
          state <= ST_IDLE;
        end else if ((script == `UFC_SC_RESET) && (step == 4'h0) &&
                     (ep_cnt != LAST_EP)) begin
          ep_cnt <= ep_cnt + 4'h1;
          state <= ST_ISSUE;
        end else begin
          step <= step + 4'h1;
          state <= ST_ISSUE;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Own registers
  // --------------------------------------------------------------------
  assign wr_en = s_psel && s_penable && s_pwrite;
  assign mapped = (s_paddr <= `UFC_R_GSTS) && (s_paddr[1:0] == 2'b00);
  assign s_pready = 1'b1;
  assign s_pslverr = s_psel && s_penable && !mapped;

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend <= 6'h00;
      events <= 6'h00;
      cfg <= 32'h00000000;
      epcfg <= 32'h00000000;
      txdata <= 32'h00000000;
      s_prdata <= 32'h00000000;
    end else begin
      // Set wins: a command or event in the clearing cycle survives
      pend <= (pend & ~pend_clr) |
              ((wr_en && s_paddr == `UFC_R_CTRL) ? s_pwdata[5:0] : 6'h00);
      events <= (events & ~((wr_en && s_paddr == `UFC_R_EVENTS) ?
                s_pwdata[5:0] : 6'h00)) | ev_set;
      if (wr_en && s_paddr == `UFC_R_CFG) begin
        cfg <= s_pwdata;
      end
      if (wr_en && s_paddr == `UFC_R_EPCFG) begin
        epcfg <= s_pwdata;
      end
      if (wr_en && s_paddr == `UFC_R_TXDATA) begin
        txdata <= s_pwdata;
      end
      if (s_psel && !s_penable) begin
        case (s_paddr)
          `UFC_R_CTRL: s_prdata <= {26'h0000000, pend};
          `UFC_R_CFG: s_prdata <= cfg;
          `UFC_R_EPCFG: s_prdata <= epcfg;
          `UFC_R_TXDATA: s_prdata <= txdata;
          `UFC_R_STATUS: s_prdata <= {{(28-NUM_EP){1'b0}}, ep_act,
                                      connected, enum_speed,
                                      state != ST_IDLE};
          `UFC_R_EVENTS: s_prdata <= {26'h0000000, events};
          `UFC_R_GSTS: s_prdata <= gsts;
          default: s_prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // ufc_ctrl

// file: ufc_defs.vh
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH

// ----------------------------------------------------------------------
// Own register offsets (APB slave, byte addresses)
// ----------------------------------------------------------------------
`define UFC_R_CTRL 8'h00
`define UFC_R_CFG 8'h04
`define UFC_R_EPCFG 8'h08
`define UFC_R_TXDATA 8'h0C
`define UFC_R_STATUS 8'h10
`define UFC_R_EVENTS 8'h14
`define UFC_R_GSTS 8'h18

// ----------------------------------------------------------------------
// Device register offsets
// ----------------------------------------------------------------------
`define UFC_D_GINTSTS 32'h00000014
`define UFC_D_GINTMSK 32'h00000018
`define UFC_D_GRXFSIZ 32'h00000024
`define UFC_D_DIEPTXF0 32'h00000028
`define UFC_D_HCCHAR 32'h00000500
`define UFC_D_HCINT 32'h00000508
`define UFC_D_HCINTMSK 32'h0000050C
`define UFC_D_HCTSIZ 32'h00000510
`define UFC_D_DCFG 32'h00000800
`define UFC_D_DCTL 32'h00000804
`define UFC_D_DSTS 32'h00000808
`define UFC_D_DIEPMSK 32'h00000810
`define UFC_D_DOEPMSK 32'h00000814
`define UFC_D_ENDPOINT_INTERRUPT_MASK_REG 32'h0000081C
`define UFC_D_DIEPCTL0 32'h00000900
`define UFC_D_DIEPINT0 32'h00000908
`define UFC_D_DIEPTSIZ0 32'h00000910
`define UFC_D_DOEPCTL0 32'h00000B00
`define UFC_D_DOEPINT0 32'h00000B08
`define UFC_D_DOEPTSIZ0 32'h00000B10
`define UFC_D_CHFIFO 32'h00001000
`define UFC_EP_SHIFT 5

// ----------------------------------------------------------------------
// Device register fields
// ----------------------------------------------------------------------
`define UFC_GI_SOF 32'h00000008
`define UFC_GI_ESUSP 32'h00000400
`define UFC_GI_SUSP 32'h00000800
`define UFC_GI_RST 32'h00001000
`define UFC_GI_ENUM 32'h00002000
`define UFC_GI_IEP 32'h00040000
`define UFC_GI_OEP 32'h00080000
`define UFC_GI_HCH 32'h02000000
`define UFC_DS_SPD 2:1
`define UFC_SPD_FULL 2'h3
`define UFC_EC_VALID 32'h00008000
`define UFC_EC_DATA0 32'h10000000
`define UFC_EC_CNAK 32'h04000000
`define UFC_EC_SET_NAK 32'h08000000
`define UFC_EC_DIS 32'h40000000
`define UFC_EC_ENA 32'h80000000
`define UFC_EC_TYPE_LSB 18
`define UFC_EC_TXF_LSB 22
`define UFC_OI_TRANSFER_COMPLETE_FLAG 32'h00000001
`define UFC_OI_SETUP 32'h00000008
`define UFC_IM_TMO 32'h00000008
`define UFC_HI_TRANSFER_COMPLETE_FLAG 32'h00000001
`define UFC_HI_HALT 32'h00000002
`define UFC_HI_OVRUN 32'h00000200
`define UFC_HC_ISO 32'h00040000
`define UFC_HC_ODD 32'h20000000
`define UFC_TS_PKT1 32'h00080000
`define UFC_TS_SUP3 32'h60000000
`define UFC_EP0_MPS 11'h040
`define UFC_EP0_MPS_LOW 11'h008
`define UFC_EP0_CHUNK 32'h00000040
`define UFC_RX_WORDS (16'h0010 + 16'h0002 + 16'h000A)
`define UFC_TX0_WORDS 16'h0010
`define UFC_DCFG_ADDR_LSB 5

// ----------------------------------------------------------------------
// Script codes
// ----------------------------------------------------------------------
`define UFC_SC_POLL 4'h0
`define UFC_SC_INIT 4'h1
`define UFC_SC_RESET 4'h2
`define UFC_SC_ENUM 4'h3
`define UFC_SC_OEP 4'h4
`define UFC_SC_HCH 4'h5
`define UFC_SC_CLR 4'h6
`define UFC_SC_SADDR 4'h7
`define UFC_SC_ACT 4'h8
`define UFC_SC_DEACT 4'h9
`define UFC_SC_CHAN 4'hA
`define UFC_SC_PUSH 4'hB
`define UFC_SC_IEP 4'hC

`endif

// file: ufc_sync.v
module ufc_sync (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;

  // A change counts only once the last two stages agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // ufc_sync

// file: ufc_apb_master.v
`include "ufc_defs.vh"

module ufc_apb_master (
  input wire clk,
  input wire rst_n,
  input wire req,
  input wire req_write,
  input wire [31:0] req_addr,
  input wire [31:0] req_wdata,
  output reg done,
  output reg [31:0] rdata,
  output reg psel,
  output reg penable,
  output reg [31:0] paddr,
  output reg pwrite,
  output reg [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready
);
  // No wait count is assumed: the access phase holds until pready
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= 32'h00000000;
      pwrite <= 1'b0;
      pwdata <= 32'h00000000;
      rdata <= 32'h00000000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (req && !psel) begin
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= req_addr;
        pwrite <= req_write;
        pwdata <= req_wdata;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        rdata <= prdata;
        done <= 1'b1;
      end
    end
  end
endmodule // ufc_apb_master

// file: ufc_checker.sv
module ufc_chk (
  input wire clk,
  input wire rst_n,
  input wire s_psel,
  input wire s_penable,
  input wire [7:0] s_paddr,
  input wire s_pslverr,
  input wire dev_irq,
  input wire m_psel,
  input wire m_penable,
  input wire [31:0] m_paddr,
  input wire m_pwrite,
  input wire [31:0] m_pwdata,
  input wire m_pready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Bus and sequence checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_slverr_map: assert property (s_psel && s_penable |->
    s_pslverr == (s_paddr > 8'h18 || s_paddr[1:0] != 2'h0))
    else $error("slave error flag wrong");
  a_setup_next: assert property (m_psel && !m_penable |=> m_psel && m_penable)
    else $error("access phase missing");
  a_req_hold: assert property (m_psel && !(m_penable && m_pready) |=>
    m_psel && $stable(m_paddr) && $stable(m_pwrite) && $stable(m_pwdata))
    else $error("request changed early");
  a_gap_idle: assert property (m_penable && m_pready |=> !m_psel [*2])
    else $error("idle gap too short");
  a_irq_served: assert property ($rose(dev_irq) && !m_psel |->
    ##[1:12] m_psel && !m_pwrite && m_paddr == 32'h14)
    else $error("status not read");
  a_setup_packet_count_three: assert property (
    m_psel && m_pwrite && m_paddr == 32'hB10 |-> m_pwdata[30:29] == 2'h3)
    else $error("setup count not three");
  a_chunk_max: assert property (
    m_psel && m_pwrite && m_paddr == 32'hB10 |-> m_pwdata[18:0] <= 19'h40)
    else $error("chunk too large");
  a_set_nak_out: assert property (
    m_psel && m_pwrite && m_paddr == 32'hB20 |-> m_pwdata[27])
    else $error("nak not forced");
endmodule // ufc_chk

bind ufc_ctrl ufc_chk chk_i (.clk(clk), .rst_n(rst_n), .s_psel(s_psel),
  .s_penable(s_penable), .s_paddr(s_paddr), .s_pslverr(s_pslverr),
  .dev_irq(dev_irq), .m_psel(m_psel), .m_penable(m_penable),
  .m_paddr(m_paddr), .m_pwrite(m_pwrite), .m_pwdata(m_pwdata),
  .m_pready(m_pready));

// file: ufc_dev_model.sv
module ufc_dev_model (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire [31:0] paddr,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:4095];
  int lat = 0;
  int cnt;
  wire [11:0] ix = paddr[13:2];
  // Summary bits follow the endpoint and channel flags
  wire [31:0] gs = mem[5] | {6'h0, |mem[322], 5'h0, |mem[706], |mem[578], 18'h0};
  wire [31:0] rv = (ix == 12'h005) ? gs : mem[ix];
  assign pready = penable && cnt >= lat;
  // Outside a reply the bus shows the inverse, never a stale copy
  assign prdata = pready ? rv : ~rv;
  assign irq = |gs;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      for (int i = 0; i < 4096; i++)
        mem[i] <= 32'h0;
      mem[513] <= 32'h2;
    end else begin
      cnt <= (psel && penable && !pready) ? cnt + 1 : 0;
      if (psel && pready && pwrite) begin
        if (ix == 12'h005 || ix == 322 || ix == 706 || ix == 578)
          mem[ix] <= mem[ix] & ~pwdata;
        else
          mem[ix] <= pwdata;
      end
    end
  end
  task ev(input logic [11:0] i, input logic [31:0] v);
    mem[i] <= mem[i] | v;
  endtask
endmodule // ufc_dev_model

// file: tb_top.sv
`include "ufc_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, s_psel = 0, s_penable = 0, s_pwrite = 0, err;
  logic [7:0] s_paddr = 8'h00;
  logic [31:0] s_pwdata = 32'h0, rd;
  wire [31:0] s_prdata, m_prdata, m_paddr, m_pwdata;
  wire s_pready, s_pslverr, dev_irq, m_psel, m_penable, m_pwrite, m_pready;
  int num_errors = 0, compares = 0;
  always #10 clk = ~clk;
  ufc_ctrl dut (.clk(clk), .rst_n(rst_n), .s_psel(s_psel),
    .s_penable(s_penable), .s_paddr(s_paddr), .s_pwrite(s_pwrite),
    .s_pwdata(s_pwdata), .s_prdata(s_prdata), .s_pready(s_pready),
    .s_pslverr(s_pslverr), .dev_irq(dev_irq), .m_psel(m_psel),
    .m_penable(m_penable), .m_paddr(m_paddr), .m_pwrite(m_pwrite),
    .m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready));
  ufc_dev_model dev (.clk(clk), .rst_n(rst_n), .psel(m_psel),
    .penable(m_penable), .paddr(m_paddr), .pwrite(m_pwrite),
    .pwdata(m_pwdata), .prdata(m_prdata), .pready(m_pready), .irq(dev_irq));
  // ----
  // Shared tasks
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function logic [31:0] m(input logic [31:0] a);
    return dev.mem[a[13:2]];
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_psel <= 1'h1;
    s_pwrite <= w;
    s_paddr <= a;
    s_pwdata <= d;
    @(posedge clk);
    s_penable <= 1'h1;
    do @(posedge clk); while (s_pready !== 1'h1);
    rd = s_prdata;
    err = s_pslverr;
    s_psel <= 1'h0;
    s_penable <= 1'h0;
  endtask
  // Polls until the device line is quiet and the controller idle
  task settle;
    int n;
    n = 0;
    do begin
      apb(1'h0, `UFC_R_STATUS, 32'h0);
      n++;
    end while ((dev_irq !== 1'h0 || rd[0] !== 1'h0) && n < 500);
    chk(n < 500, 32'h1);
  endtask
  task cmd(input logic [31:0] c);
    apb(1'h1, `UFC_R_CTRL, c);
    settle;
  endtask
  // ----
  // Scenarios
  // ----
  task t_init;
    apb(1'h1, `UFC_R_CFG, 32'h0000054F);
    cmd(32'h1);
    chk(m(`UFC_D_DCTL), 32'h0);
    chk(m(`UFC_D_GINTMSK) & 32'h3C08, 32'h3C08);
    cmd(32'h2);
    chk((m(`UFC_D_DCFG) >> `UFC_DCFG_ADDR_LSB) & 32'h7F, 32'h2A);
    chk(m(`UFC_D_DIEPCTL0) & `UFC_EC_ENA, `UFC_EC_ENA);
  endtask
  task t_rst;
    dev.ev(12'h005, `UFC_GI_RST);
    settle;
    chk(m(32'hB60) & `UFC_EC_SET_NAK, `UFC_EC_SET_NAK);
    chk(m(`UFC_D_DOEPMSK), 32'h9);
    chk(m(`UFC_D_DIEPMSK), 32'h9);
    chk(m(`UFC_D_GRXFSIZ) >= 32'h1C, 32'h1);
    chk((m(`UFC_D_DCFG) >> `UFC_DCFG_ADDR_LSB) & 32'h7F, 32'h0);
    chk(m(`UFC_D_DOEPTSIZ0) >> 29, 32'h3);
    dev.ev(12'h202, 32'h6);
    dev.ev(12'h005, `UFC_GI_ENUM);
    settle;
    chk(m(`UFC_D_DIEPCTL0) & 32'h7FF, 32'h40);
    chk(m(`UFC_D_GINTMSK) & `UFC_GI_SOF, `UFC_GI_SOF);
    chk(rd & 32'hE, 32'hE);
  endtask
  task t_setup;
    dev.lat = 3;
    dev.ev(12'h2C2, `UFC_OI_SETUP | `UFC_OI_TRANSFER_COMPLETE_FLAG);
    settle;
    chk(m(`UFC_D_DOEPTSIZ0), 32'h60080040);
    chk(m(`UFC_D_DOEPCTL0) & `UFC_EC_ENA, `UFC_EC_ENA);
    apb(1'h0, `UFC_R_EVENTS, 32'h0);
    chk(rd, 32'hF);
    dev.ev(12'h142, `UFC_HI_OVRUN);
    settle;
    chk(m(`UFC_D_HCINTMSK) & 32'h2, 32'h2);
    chk(m(`UFC_D_HCCHAR) & 32'hC0000000, 32'hC0000000);
    dev.ev(12'h142, `UFC_HI_HALT);
    settle;
    chk(m(`UFC_D_HCINTMSK) & 32'h2, 32'h0);
    chk(m(`UFC_D_HCCHAR), 32'h0);
    dev.ev(12'h142, `UFC_HI_TRANSFER_COMPLETE_FLAG);
    settle;
    apb(1'h0, `UFC_R_EVENTS, 32'h0);
    chk(rd, 32'h3F);
    dev.ev(12'h242, 32'h1);
    settle;
    chk(m(32'h908), 32'h0);
  endtask
  task t_act;
    apb(1'h1, `UFC_R_EPCFG, 32'h00030401);
    cmd(32'h4);
    chk(rd & 32'h20, 32'h20);
    chk(m(32'h920) & `UFC_EC_VALID, `UFC_EC_VALID);
    cmd(32'h8);
    chk(m(32'h920) & `UFC_EC_VALID, 32'h0);
    chk(rd & 32'h20, 32'h0);
    apb(1'h0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    cmd(32'h10);
    chk(m(`UFC_D_HCCHAR), 32'hA0040040);
    apb(1'h1, `UFC_R_TXDATA, 32'hA5C3);
    cmd(32'h20);
    chk(m(`UFC_D_CHFIFO), 32'hA5C3);
  endtask
  task end_of_test;
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    t_init;
    t_rst;
    t_setup;
    t_act;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
endmodule // tb_top
